// *** dv/psc_prev_model.sv ***
// Model of the previous module in the chain, the source of the sync pulses
`timescale 1ns/1ps
`default_nettype none
module psc_prev_model
(
  // Clock
  input wire logic mclk,
  // Requests from the bench
  input wire logic fire,
  input wire logic withXfer,
  // Chain outputs
  output logic syncOut,
  output logic transEnableOut
);
  // Shadow pulse only ever rides beside a sync pulse
  always_ff @(posedge mclk)
  begin
    syncOut <= fire;
    transEnableOut <= fire & withXfer;
  end
endmodule
`default_nettype wire

// *** dv/pwm_sync_chain_tb_top.sv ***
// Bench for the synchronised PWM module
`timescale 1ns/1ps
`default_nettype none
module pwm_sync_chain_tb_top;
  import psc_pkg::*;
  logic mclk = 0, rst = 1, runEn = 0, slaveEn = 0, shReq = 0;
  logic fire = 0, withXfer = 0;
  logic [15:0] dly = 16'h0000;
  logic [95:0] riseM = '0, fallM = '0;
  logic [5:0] faultLvl = '0;
  logic [2:0] capPin = '0;
  logic rOnce = 0, trapEn = 0, faultPin = 0;
  logic [15:0] preLim = 16'h0000, perLim = 16'hffff;
  logic syncIn, transIn, syncOut, transOut, running, trapIrq;
  logic [5:0] wave;
  logic [47:0] capVal;
  int errCount = 0, comparisons = 0, cyc = 0;
  int expCyc[$];
  logic expTr[$];
  psc_prev_model prev (.mclk(mclk), .fire(fire), .withXfer(withXfer),
    .syncOut(syncIn), .transEnableOut(transIn));
  psc_pwm_core dut (.mclk(mclk), .rst(rst), .runEnable(runEn),
    .runOnce(rOnce), .slaveEnable(slaveEn), .prescaleLimit(preLim),
    .periodLimit(perLim), .syncDelay(dly), .shadowReq(shReq),
    .riseMatch(riseM), .fallMatch(fallM), .faultLevel(faultLvl),
    .trapIrqEnable(trapEn), .syncIn(syncIn), .transEnableIn(transIn),
    .capture_trigger_pin(capPin), .fault_hold_pin(faultPin),
    .waveform_output_pin(wave), .syncOut(syncOut),
    .transEnableOut(transOut), .captureValue(capVal), .trapIrq(trapIrq),
    .running(running));
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      errCount++;
    end
  endtask
  task automatic results();
    $display("errCount=%0d comparisons=%0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Master start: expected pulse cycles noted before the counter restarts
  task automatic master(input logic [15:0] d, input logic sh, input int n);
    int per;
    per = (int'(perLim) + 1) * (int'(preLim) + 1);
    runEn = 0;
    shReq = sh;
    dly = d;
    @(posedge mclk);
    #2 shReq = 0;
    @(posedge mclk);
    #2 runEn = 1;
    for (int j = 0; j < n; j++)
    begin
      expCyc.push_back(cyc + 2 + d + j * per);
      expTr.push_back(sh && j == 0);
    end
    repeat (d + 6 + (n - 1) * per) @(posedge mclk);
    #2;
  endtask
  // Slave pulses are one cycle later than a master start: the model registers
  task automatic pulse(input logic x);
    if (slaveEn)
    begin
      expCyc.push_back(cyc + 3 + dly);
      expTr.push_back(x);
    end
    fire = 1;
    withXfer = x;
    @(posedge mclk);
    #2 fire = 0;
    repeat (dly + 5) @(posedge mclk);
    #2;
  endtask
  // Rises early and falls late; sampled once after every rise, then all pins captured
  task automatic shape();
    int n;
    logic [5:0] expW;
    n = $urandom_range(8, 23);
    for (int g = 0; g < 6; g++)
    begin
      riseM[g*16 +: 16] = 16'($urandom_range(0, 7));
      fallM[g*16 +: 16] = 16'($urandom_range(8, 23));
      expW[g] = n < fallM[g*16 +: 16];
    end
    master(16'h0000, 1'b1, 1);
    repeat (n - 4) @(posedge mclk);
    #2 check(wave, expW);
    capPin = 3'b111;
    @(posedge mclk);
    #2 check(capVal, {3{16'(n + 1)}});
    capPin = 3'b000;
  endtask
  // Watch the chain outputs once they have settled
  always @(negedge mclk)
  begin
    if (syncOut === 1'b1)
    begin
      if (expCyc.size() == 0)
        check(1, 0);
      else
      begin
        check(cyc, expCyc.pop_front());
        check(transOut, expTr.pop_front());
      end
    end
    else if (transOut === 1'b1)
      check(1, 0);
  end
  // Cycle count doubles as the hang limit
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      errCount++;
      results();
    end
  end
  initial
  begin
    void'($urandom(32'h2acb_d02e));
    repeat (8) @(posedge mclk);
    #2 rst = 0;
    master(16'h0000, 1'b1, 1);
    master(16'h0000, 1'b0, 1);
    for (int i = 0; i < 5; i++)
      master(16'($urandom_range(1, 6)), 1'($urandom_range(0, 1)), 1);
    shape();
    // Periods of at least 8 cycles keep the next restart past each call
    preLim = 16'($urandom_range(0, 1));
    perLim = 16'($urandom_range(7, 9));
    master(16'($urandom_range(0, 2)), 1'b1, 3);
    rOnce = 1;
    master(16'h0000, 1'b0, 1);
    check(running, 1);
    repeat (20) @(posedge mclk);
    #2 check(running, 0);
    rOnce = 0;
    preLim = 16'h0000;
    perLim = 16'hffff;
    faultLvl = 6'($urandom);
    trapEn = 1'($urandom);
    faultPin = 1;
    @(posedge mclk);
    #2 check({trapIrq, wave}, {trapEn, faultLvl});
    faultPin = 0;
    @(posedge mclk);
    #2 check(trapIrq, 0);
    dly = 16'($urandom_range(0, 6));
    runEn = 0;
    @(posedge mclk);
    #2 slaveEn = 1;
    runEn = 1;
    repeat (3) @(posedge mclk);
    #2 check(running, 0);
    slaveEn = 0;
    pulse(1'($urandom_range(0, 1)));
    check(running, 0);
    slaveEn = 1;
    pulse(1'($urandom_range(0, 1)));
    check(running, 1);
    check(expCyc.size(), 0);
    results();
  end
endmodule
`default_nettype wire

// *** logic/psc_pkg.sv ***
// Shared constants for the synchronised PWM module
`default_nettype none
package psc_pkg;
  localparam int CNT_W = 16;
  localparam int NUM_OUT = 6;
  localparam int NUM_CAP = 3;
  localparam int DLY_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] PRE_RESET = 16'h0000;
  localparam logic [15:0] DLY_ZERO = 16'h0000;
endpackage
`default_nettype wire

// *** logic/psc_pwm_core.sv ***
// One PWM module with master/slave period synchronisation
`timescale 1ns/1ps
`default_nettype none
module psc_pwm_core
  import psc_pkg::*;
#(
  parameter int NOUT = NUM_OUT,
  parameter int NCAP = NUM_CAP
)
(
  // Clock and reset; the clock is the gated branch clock
  input wire logic mclk,
  input wire logic rst,
  // Configuration
  input wire logic runEnable,
  input wire logic runOnce,
  input wire logic slaveEnable,
  input wire logic [CNT_W-1:0] prescaleLimit,
  input wire logic [CNT_W-1:0] periodLimit,
  input wire logic [DLY_W-1:0] syncDelay,
  input wire logic shadowReq,
  input wire logic [NOUT*CNT_W-1:0] riseMatch,
  input wire logic [NOUT*CNT_W-1:0] fallMatch,
  input wire logic [NOUT-1:0] faultLevel,
  input wire logic trapIrqEnable,
  // Chain inputs from the previous module
  input wire logic syncIn,
  input wire logic transEnableIn,
  // Pins
  input wire logic [NCAP-1:0] capture_trigger_pin,
  input wire logic fault_hold_pin,
  output logic [NOUT-1:0] waveform_output_pin,
  // Chain outputs to the next module
  output logic syncOut,
  output logic transEnableOut,
  // Status
  output logic [NCAP*CNT_W-1:0] captureValue,
  output logic trapIrq,
  output logic running
);
  logic [CNT_W-1:0] pre_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic run_ff;
  logic runEnPrev_ff;
  logic pending_ff;
  logic restart_ff;
  logic xfer_ff;
  logic [NOUT*CNT_W-1:0] riseSh_ff;
  logic [NOUT*CNT_W-1:0] fallSh_ff;
  logic [NOUT-1:0] wave_ff;
  logic [NCAP*CNT_W-1:0] cap_ff;
  logic [NCAP-1:0] capPrev_ff;
  logic trapIrq_ff;
  logic tick;
  logic periodEnd;
  logic slaveRestart;
  logic slaveXfer;
  logic restartNow;

  // everything below sits on mclk; gating is done outside
  assign tick = run_ff && (pre_ff == prescaleLimit);
  assign periodEnd = tick && (cnt_ff == periodLimit);
  assign slaveRestart = slaveEnable && syncIn;
  assign slaveXfer = slaveEnable && transEnableIn;
  assign restartNow = slaveRestart || (periodEnd && !runOnce)
    || (runEnable && !runEnPrev_ff && !slaveEnable);

  // Master start is the rising edge of runEnable only, so that run-once
  // really stops and a slave dropping its role does not self-start
  always_ff @(posedge mclk)
  begin
    if (rst)
      runEnPrev_ff <= 1'b0;
    else
      runEnPrev_ff <= runEnable;
  end

  // Prescale and period counters
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pre_ff <= PRE_RESET;
      cnt_ff <= CNT_RESET;
      run_ff <= 1'b0;
    end
    else if (!runEnable)
    begin
      run_ff <= 1'b0;
      pre_ff <= PRE_RESET;
      cnt_ff <= CNT_RESET;
    end
    else if (restartNow)
    begin
      run_ff <= 1'b1;
      pre_ff <= PRE_RESET;
      cnt_ff <= CNT_RESET;
    end
    else if (periodEnd)
      run_ff <= 1'b0;
    else if (run_ff)
    begin
      pre_ff <= tick ? PRE_RESET : pre_ff + 1'b1;
      if (tick)
        cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Shadow copy: at own restart in master role, on input pulse as slave
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pending_ff <= 1'b0;
      riseSh_ff <= '0;
      fallSh_ff <= '0;
      restart_ff <= 1'b0;
      xfer_ff <= 1'b0;
    end
    else
    begin
      restart_ff <= restartNow && runEnable;
      xfer_ff <= 1'b0;
      if (shadowReq)
        pending_ff <= 1'b1;
      if ((slaveEnable && slaveXfer) ||
          (!slaveEnable && restartNow && runEnable && pending_ff))
      begin
        riseSh_ff <= riseMatch;
        fallSh_ff <= fallMatch;
        pending_ff <= shadowReq;
        xfer_ff <= !slaveEnable || slaveRestart;
      end
    end
  end

  psc_sync_delay u_delay (
    .mclk(mclk),
    .rst(rst),
    .restartPulse(restart_ff),
    .xferPulse(xfer_ff),
    .delayCycles(syncDelay),
    .syncOut_ff(syncOut),
    .xferOut_ff(transEnableOut)
  );

  // Waveforms with trap hold
  genvar g;
  generate
    for (g = 0; g < NOUT; g++)
    begin : gOut
      always_ff @(posedge mclk)
      begin
        if (rst)
          wave_ff[g] <= 1'b0;
        else if (fault_hold_pin)
          wave_ff[g] <= faultLevel[g];
        else if (run_ff && cnt_ff == riseSh_ff[g*CNT_W +: CNT_W])
          wave_ff[g] <= 1'b1;
        else if (run_ff && cnt_ff == fallSh_ff[g*CNT_W +: CNT_W])
          wave_ff[g] <= 1'b0;
      end
    end
    for (g = 0; g < NCAP; g++)
    begin : gCap
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          cap_ff[g*CNT_W +: CNT_W] <= CNT_RESET;
          capPrev_ff[g] <= 1'b0;
        end
        else
        begin
          capPrev_ff[g] <= capture_trigger_pin[g];
          if (capture_trigger_pin[g] && !capPrev_ff[g])
            cap_ff[g*CNT_W +: CNT_W] <= cnt_ff;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (rst)
      trapIrq_ff <= 1'b0;
    else
      trapIrq_ff <= fault_hold_pin && trapIrqEnable;
  end

  assign waveform_output_pin = wave_ff;
  assign captureValue = cap_ff;
  assign trapIrq = trapIrq_ff;
  assign running = run_ff;

  a_trap_hold: assert property (@(posedge mclk) disable iff (rst)
    fault_hold_pin |=> waveform_output_pin == $past(faultLevel))
    else $error("outputs not held on fault");
  a_slave_align: assert property (@(posedge mclk) disable iff (rst)
    runEnable && slaveEnable && syncIn && !fault_hold_pin
      |=> cnt_ff == CNT_RESET && run_ff)
    else $error("slave did not restart");
  a_master_pulse: assert property (@(posedge mclk) disable iff (rst)
    restartNow && runEnable && syncDelay == DLY_ZERO |-> ##2 syncOut)
    else $error("period pulse missing");
  // Also watches the cycle after the stop, where a stray restart would show
  a_run_once: assert property (@(posedge mclk) disable iff (rst)
    periodEnd && runOnce && !slaveRestart && runEnable
      |=> !run_ff ##1 (!run_ff || $past(slaveRestart)))
    else $error("run-once did not stop");
  a_ignore_slave: assert property (@(posedge mclk) disable iff (rst)
    !slaveEnable && run_ff && !periodEnd && runEnable ##1 run_ff
      |-> cnt_ff != CNT_RESET || $past(cnt_ff) == CNT_RESET
      || $past(tick))
    else $error("counter reset unexpectedly");
endmodule
`default_nettype wire

// *** logic/psc_sync_delay.sv ***
// Programmable delay for the outgoing period-start and shadow-update pulses
`timescale 1ns/1ps
`default_nettype none
module psc_sync_delay
  import psc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Restart event
  input wire logic restartPulse,
  input wire logic xferPulse,
  input wire logic [DLY_W-1:0] delayCycles,
  // Delayed pulses
  output logic syncOut_ff,
  output logic xferOut_ff
);
  logic [DLY_W-1:0] dlyCnt_ff;
  logic busy_ff;
  logic xferHeld_ff;

  // A restart during a running delay restarts the delay; periods no longer
  // than the delay therefore never emit pulses.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dlyCnt_ff <= DLY_ZERO;
      busy_ff <= 1'b0;
      xferHeld_ff <= 1'b0;
      syncOut_ff <= 1'b0;
      xferOut_ff <= 1'b0;
    end
    else
    begin
      syncOut_ff <= 1'b0;
      xferOut_ff <= 1'b0;
      if (restartPulse && delayCycles == DLY_ZERO)
      begin
        syncOut_ff <= 1'b1;
        xferOut_ff <= xferPulse;
        busy_ff <= 1'b0;
      end
      else if (restartPulse)
      begin
        dlyCnt_ff <= delayCycles;
        xferHeld_ff <= xferPulse;
        busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
        dlyCnt_ff <= dlyCnt_ff - 1'b1;
        if (dlyCnt_ff == 16'h0001)
        begin
          busy_ff <= 1'b0;
          syncOut_ff <= 1'b1;
          xferOut_ff <= xferHeld_ff;
        end
      end
    end
  end

  a_pulse_single: assert property (@(posedge mclk) disable iff (rst)
    syncOut_ff |=> !syncOut_ff || $past(restartPulse))
    else $error("sync pulse longer than one cycle");
  a_xfer_with_sync: assert property (@(posedge mclk) disable iff (rst)
    xferOut_ff |-> syncOut_ff)
    else $error("shadow pulse without period pulse");
  a_zero_delay: assert property (@(posedge mclk) disable iff (rst)
    restartPulse && delayCycles == DLY_ZERO |=> syncOut_ff)
    else $error("undelayed pulse missing");
endmodule
`default_nettype wire
